// file: ppt_pkg.sv
// Package for the parallel port timing and status block.
// Assumes a 16-bit register port and one clock of 200 MHz.
package ppt_pkg;
   // ------------------------------------------------------------
   // Register offsets (word addresses on the plain register port)
   // ------------------------------------------------------------
   localparam logic [3:0] OFS_CS1_MODE = 4'h0;
   localparam logic [3:0] OFS_CS2_MODE = 4'h1;
   localparam logic [3:0] OFS_CS1_CFG = 4'h2;
   localparam logic [3:0] OFS_CS2_CFG = 4'h3;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_PAD_CFG = 4'h5;
   localparam logic [3:0] OFS_MSTAT = 4'h6;
   localparam logic [3:0] OFS_IBUF0 = 4'h8; // 8..B input buffers
   localparam logic [3:0] OFS_OBUF0 = 4'hC; // C..F output buffers
   // ------------------------------------------------------------
   // Mode, configuration and status register fields
   // ------------------------------------------------------------
   localparam int ACK_MODE_LSB = 14;
   localparam int AMW_LSB = 11;
   localparam int DSW_LSB = 6;
   localparam int STW_LSB = 2;
   localparam int DHW_LSB = 0;
   localparam int CFG_ACK_POLARITY_BIT = 7;
   localparam int ST_IALL = 15;
   localparam int ST_IOV = 14;
   localparam int ST_OALL = 7;
   localparam int ST_OUND = 6;
   localparam int MS_TOUT = 12;
   localparam int MS_BUSY = 0;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] STATUS_RST = 16'h008F;
   // ------------------------------------------------------------
   // Acknowledge modes and timing
   // ------------------------------------------------------------
   localparam logic [1:0] ACK_NONE = 2'h0;
   localparam logic [1:0] ACK_TOUT = 2'h1;
   localparam logic [1:0] ACK_WAIT = 2'h2;
   localparam logic [7:0] TOUT_DEFAULT = 8'hFF;
   localparam logic [2:0] AMW_BASE = 3'h3;
   // Clocks per quarter instruction cycle (instruction cycle = 4 clk)
   localparam int CLK_MHZ = 200;
   localparam int TCY_NS = 20;
   localparam int QTR_CLKS = (TCY_NS * CLK_MHZ) / (4 * 1000);
   typedef enum logic [2:0] {
      PPT_IDLE = 3'b000,
      PPT_SETUP = 3'b001,
      PPT_STROBE = 3'b010,
      PPT_ACKW = 3'b011,
      PPT_HOLD = 3'b100,
      PPT_ALTW = 3'b101
   } ppt_state_e;
endpackage

// file: ppt_qtick.sv
// Quarter instruction cycle tick generator.
// Assumes synchronous active-high reset.
`timescale 1ns/100ps
module ppt_qtick #(
   parameter int DIV = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   output logic tick
);
   logic [7:0] cnt_r;
   // ------------------------------------------------------------
   // Divider
   // ------------------------------------------------------------
   // One pulse every DIV clocks
   always_ff @(posedge clk_sys) begin
      if (rst || cnt_r == 8'(DIV - 1)) begin
         cnt_r <= 8'h00;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end
   assign tick = (cnt_r == 8'(DIV - 1)) && !rst;
endmodule

// file: ppt_bufflag.sv
// One word pair of slave buffer flags.
// Assumes one-cycle event pulses from host and software sides.
`timescale 1ns/100ps
module ppt_bufflag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic set_ev,
   input wire logic clr_ev,
   output logic flag_r
);
   // ------------------------------------------------------------
   // Flag pair state
   // ------------------------------------------------------------
   // Set wins over clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_r <= RST_VAL;
      end else if (set_ev) begin
         flag_r <= 1'b1;
      end else if (clr_ev) begin
         flag_r <= 1'b0;
      end
   end
endmodule

// file: ppt_top.sv
// Parallel port strobe timing, acknowledge and slave buffer status.
// Assumes synchronous inputs, 200 MHz clock, plain register port.
`timescale 1ns/100ps
module ppt_top #(
   parameter int QDIV = ppt_pkg::QTR_CLKS
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic xfer_req,
   input wire logic xfer_write,
   input wire logic xfer_cs,
   input wire logic [15:0] xfer_wdata,
   output logic xfer_done,
   output logic [15:0] xfer_rdata,
   output logic cs_out,
   output logic rd_strobe,
   output logic wr_strobe,
   output logic [15:0] data_out,
   output logic data_oe_n,
   input wire logic [15:0] data_in,
   input wire logic transfer_ack_in,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [1:0] host_addr,
   input wire logic [7:0] host_wdata,
   output logic [7:0] host_rdata,
   output logic ttl_input_select
);
   logic [15:0] mode_r [2];
   logic [15:0] cfg_r [2];
   logic ttl_r;
   logic tout_r;
   logic iov_r;
   logic ound_r;
   logic [7:0] ibuf_r [4];
   logic [7:0] output_underflow_r [4];
   logic [1:0] ifull;
   logic [1:0] oempty;
   logic qt;
   ppt_pkg::ppt_state_e st_r;
   logic [5:0] qcnt_r;
   logic [7:0] tcnt_r;
   logic cs_sel_r;
   logic wr_r;
   logic [15:0] m;
   logic ack_act;
   logic [1:0] ack_mode;
   logic [7:0] tlim;

   // ------------------------------------------------------------
   // Quarter-cycle timebase
   // ------------------------------------------------------------
   ppt_qtick #(.DIV(QDIV)) u_qt (
      .clk_sys(clk_sys),
      .rst(rst),
      .tick(qt)
   );

   // ------------------------------------------------------------
   // Slave buffer flags, one instance per word pair
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pair
         // Input pair: host write sets, software read clears
         ppt_bufflag #(.RST_VAL(1'b0)) u_if (
            .clk_sys(clk_sys),
            .rst(rst),
            .set_ev(host_wr && host_addr[1] == 1'(g)),
            .clr_ev(reg_rd && reg_addr[3:2] == 2'h2
                    && reg_addr[1] == 1'(g)),
            .flag_r(ifull[g])
         );
         // Output pair: host read sets, software write clears
         ppt_bufflag #(.RST_VAL(1'b1)) u_of (
            .clk_sys(clk_sys),
            .rst(rst),
            .set_ev(host_rd && host_addr[1] == 1'(g)),
            .clr_ev(reg_wr && reg_addr[3:2] == 2'h3
                    && reg_addr[1] == 1'(g)),
            .flag_r(oempty[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   // Mode and configuration registers
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mode_r[0] <= ppt_pkg::MODE_RST;
         mode_r[1] <= ppt_pkg::MODE_RST;
         cfg_r[0] <= ppt_pkg::MODE_RST;
         cfg_r[1] <= ppt_pkg::MODE_RST;
         ttl_r <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            ppt_pkg::OFS_CS1_MODE: mode_r[0] <= reg_wdata & 16'hF8FF;
            ppt_pkg::OFS_CS2_MODE: mode_r[1] <= reg_wdata & 16'hF8FF;
            ppt_pkg::OFS_CS1_CFG: cfg_r[0] <= reg_wdata & 16'h0080;
            ppt_pkg::OFS_CS2_CFG: cfg_r[1] <= reg_wdata & 16'h0080;
            ppt_pkg::OFS_PAD_CFG: ttl_r <= reg_wdata[0];
            default: ;
         endcase
      end
   end

   // Pad buffer select straight from its flip-flop
   assign ttl_input_select = ttl_r;

   // Sticky overflow and underflow; set wins over software clear
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         iov_r <= 1'b0;
         ound_r <= 1'b0;
      end else begin
         if (host_wr && ifull[host_addr[1]]) begin
            iov_r <= 1'b1;
         end else if (reg_wr && reg_addr == ppt_pkg::OFS_STATUS
                      && !reg_wdata[ppt_pkg::ST_IOV]) begin
            iov_r <= 1'b0;
         end
         if (host_rd && oempty[host_addr[1]]) begin
            ound_r <= 1'b1;
         end else if (reg_wr && reg_addr == ppt_pkg::OFS_STATUS
                      && !reg_wdata[ppt_pkg::ST_OUND]) begin
            ound_r <= 1'b0;
         end
      end
   end

   // Buffer storage: host fills inputs, software fills outputs
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         for (int i = 0; i < 4; i++) begin
            ibuf_r[i] <= 8'h00;
            output_underflow_r[i] <= 8'h00;
         end
      end else begin
         if (host_wr) begin
            ibuf_r[host_addr] <= host_wdata;
         end
         if (reg_wr && reg_addr[3:2] == 2'h3) begin
            output_underflow_r[reg_addr[1:0]] <= reg_wdata[7:0];
         end
      end
   end

   // Host read data
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         host_rdata <= 8'h00;
      end else if (host_rd) begin
         host_rdata <= output_underflow_r[host_addr];
      end
   end

   // ------------------------------------------------------------
   // Register reads, data one cycle after strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            ppt_pkg::OFS_CS1_MODE: reg_rdata <= mode_r[0];
            ppt_pkg::OFS_CS2_MODE: reg_rdata <= mode_r[1];
            ppt_pkg::OFS_CS1_CFG: reg_rdata <= cfg_r[0];
            ppt_pkg::OFS_CS2_CFG: reg_rdata <= cfg_r[1];
            ppt_pkg::OFS_STATUS: begin
               reg_rdata <= {&ifull, iov_r, 2'b00,
                             ifull[1], ifull[1], ifull[0], ifull[0],
                             &oempty, ound_r, 2'b00,
                             oempty[1], oempty[1], oempty[0], oempty[0]};
            end
            ppt_pkg::OFS_PAD_CFG: reg_rdata <= {15'h0000, ttl_r};
            ppt_pkg::OFS_MSTAT: begin
               reg_rdata <= {3'h0, tout_r, 11'h000,
                             st_r != ppt_pkg::PPT_IDLE};
            end
            ppt_pkg::OFS_IBUF0, 4'h9, 4'hA, 4'hB:
               reg_rdata <= {8'h00, ibuf_r[reg_addr[1:0]]};
            ppt_pkg::OFS_OBUF0, 4'hD, 4'hE, 4'hF:
               reg_rdata <= {8'h00, output_underflow_r[reg_addr[1:0]]};
            default: reg_rdata <= 16'h0000;
         endcase
      end else begin
         reg_rdata <= 16'h0000;
      end
   end

   // ------------------------------------------------------------
   // Master transfer sequencer
   // ------------------------------------------------------------
   assign m = mode_r[cs_sel_r];
   assign ack_mode = m[ppt_pkg::ACK_MODE_LSB +: 2];
   // Acknowledge polarity per chip select
   assign ack_act = cfg_r[cs_sel_r][ppt_pkg::CFG_ACK_POLARITY_BIT]
                    ? transfer_ack_in : !transfer_ack_in;
   // Time-out limit in instruction cycles
   assign tlim = (m[ppt_pkg::STW_LSB +: 4] == 4'h0)
                 ? ppt_pkg::TOUT_DEFAULT
                 : {4'h0, m[ppt_pkg::STW_LSB +: 4]};

   // Phase state, quarter counter, time-out counter
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= ppt_pkg::PPT_IDLE;
         qcnt_r <= 6'h00;
         tcnt_r <= 8'h00;
         cs_sel_r <= 1'b0;
         wr_r <= 1'b0;
         tout_r <= 1'b0;
         xfer_done <= 1'b0;
         xfer_rdata <= 16'h0000;
      end else begin
         xfer_done <= 1'b0;
         case (st_r)
            ppt_pkg::PPT_IDLE: begin
               if (xfer_req) begin
                  cs_sel_r <= xfer_cs;
                  wr_r <= xfer_write;
                  // Setup: code plus one quarter
                  qcnt_r <= {2'b00, mode_r[xfer_cs][7:6], 2'b00}
                            + 6'h01;
                  st_r <= ppt_pkg::PPT_SETUP;
               end
            end
            ppt_pkg::PPT_SETUP: begin
               if (qt) begin
                  if (qcnt_r == 6'h01) begin
                     // Strobe: code plus half (write) or 3/4 (read)
                     qcnt_r <= {m[5:2], 2'b00}
                               + (wr_r ? 6'h02 : 6'h03);
                     tcnt_r <= 8'h00;
                     st_r <= ppt_pkg::PPT_STROBE;
                  end else begin
                     qcnt_r <= qcnt_r - 6'h01;
                  end
               end
            end
            ppt_pkg::PPT_STROBE: begin
               if (qt) begin
                  if (qcnt_r == 6'h01) begin
                     if (ack_mode == ppt_pkg::ACK_WAIT
                         || ack_mode == ppt_pkg::ACK_TOUT) begin
                        st_r <= ppt_pkg::PPT_ACKW;
                        tcnt_r <= 8'h00;
                        qcnt_r <= 6'h00;
                     end else begin
                        st_r <= ppt_pkg::PPT_HOLD;
                        tout_r <= 1'b0;
                        xfer_rdata <= data_in;
                        // Hold: write code+1/4, read whole cycles
                        qcnt_r <= {2'b00, m[1:0], 2'b00}
                                  + (wr_r ? 6'h01 : 6'h00);
                     end
                  end else begin
                     qcnt_r <= qcnt_r - 6'h01;
                  end
               end
            end
            ppt_pkg::PPT_ACKW: begin
               if (ack_act) begin
                  st_r <= ppt_pkg::PPT_HOLD;
                  tout_r <= 1'b0;
                  xfer_rdata <= data_in;
                  qcnt_r <= {2'b00, m[1:0], 2'b00}
                            + (wr_r ? 6'h01 : 6'h00);
               end else if (qt) begin
                  // Quarter ticks grouped into instruction cycles
                  qcnt_r <= qcnt_r + 6'h01;
                  if (qcnt_r[1:0] == 2'b11) begin
                     tcnt_r <= tcnt_r + 8'h01;
                     if (ack_mode == ppt_pkg::ACK_TOUT
                         && tcnt_r + 8'h01 >= tlim) begin
                        tout_r <= 1'b1;
                        st_r <= ppt_pkg::PPT_HOLD;
                        qcnt_r <= {2'b00, m[1:0], 2'b00}
                                  + (wr_r ? 6'h01 : 6'h00);
                     end
                  end
               end
            end
            ppt_pkg::PPT_HOLD: begin
               if (qcnt_r == 6'h00) begin
                  // Alternate-master wait in instruction cycles
                  // Widened first so code 7 gives ten, not a wrapped sum
                  tcnt_r <= 8'(m[13:11]) + 8'(ppt_pkg::AMW_BASE);
                  qcnt_r <= 6'h00;
                  xfer_done <= 1'b1;
                  st_r <= ppt_pkg::PPT_ALTW;
               end else if (qt) begin
                  qcnt_r <= qcnt_r - 6'h01;
               end
            end
            ppt_pkg::PPT_ALTW: begin
               if (tcnt_r == 8'h00) begin
                  st_r <= ppt_pkg::PPT_IDLE;
               end else if (qt) begin
                  qcnt_r <= qcnt_r + 6'h01;
                  if (qcnt_r[1:0] == 2'b11) begin
                     tcnt_r <= tcnt_r - 8'h01;
                  end
               end
            end
            default: st_r <= ppt_pkg::PPT_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Pin outputs, registered
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cs_out <= 1'b0;
         rd_strobe <= 1'b0;
         wr_strobe <= 1'b0;
         data_out <= 16'h0000;
         data_oe_n <= 1'b1;
      end else begin
         cs_out <= st_r != ppt_pkg::PPT_IDLE
                   && st_r != ppt_pkg::PPT_ALTW;
         rd_strobe <= !wr_r && (st_r == ppt_pkg::PPT_STROBE
                                || st_r == ppt_pkg::PPT_ACKW);
         wr_strobe <= wr_r && (st_r == ppt_pkg::PPT_STROBE
                               || st_r == ppt_pkg::PPT_ACKW);
         if (st_r == ppt_pkg::PPT_IDLE && xfer_req) begin
            data_out <= xfer_wdata;
         end
         // Write data driven through setup, strobe and hold
         data_oe_n <= !(wr_r && st_r != ppt_pkg::PPT_IDLE
                        && st_r != ppt_pkg::PPT_ALTW);
      end
   end
endmodule

// file: ppt_asserts.sv
// Checker for the parallel port timing block, top ports only.
// Assumes a mode and polarity shadow taken from register writes.
`timescale 1ns/100ps
module ppt_asserts #(
   parameter int QDIV = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic xfer_req,
   input wire logic xfer_write,
   input wire logic xfer_cs,
   input wire logic xfer_done,
   input wire logic cs_out,
   input wire logic rd_strobe,
   input wire logic wr_strobe,
   input wire logic data_oe_n,
   input wire logic transfer_ack_in,
   input wire logic ttl_input_select
);
   logic [15:0] md_r [2];
   logic [1:0] pol_r;
   logic sel_r, wr_r, seen_r, stb, plain;
   logic [7:0] hi_r, pre_r, post_r;
   logic [15:0] m;
   assign m = md_r[sel_r];
   assign stb = rd_strobe || wr_strobe;
   assign plain = m[15] == m[14];
   // Shadow of mode and polarity, transfer kind
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         md_r[0] <= 16'h0000;
         md_r[1] <= 16'h0000;
         pol_r <= 2'h0;
      end else if (reg_wr && reg_addr[3:1] == 3'h0) begin
         md_r[reg_addr[0]] <= reg_wdata;
      end else if (reg_wr && reg_addr[3:1] == 3'h1) begin
         pol_r[reg_addr[0]] <= reg_wdata[7];
      end
      if (xfer_req) begin
         sel_r <= xfer_cs;
         wr_r <= xfer_write;
      end
   end
   // Phase length counters
   always_ff @(posedge clk_sys) begin
      hi_r <= stb ? hi_r + 8'h01 : 8'h00;
      if (rst || xfer_req) begin
         pre_r <= 8'h00;
         post_r <= 8'h00;
         seen_r <= 1'b0;
      end else begin
         if (cs_out && !stb && post_r == 8'h00)
            pre_r <= pre_r + 8'h01;
         if ($fell(stb))
            post_r <= 8'h01;
         else if (post_r != 8'h00)
            post_r <= post_r + 8'h01;
         if (cs_out && transfer_ack_in == pol_r[sel_r])
            seen_r <= 1'b1;
      end
   end
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_pad_wr;
      reg_wr && reg_addr == ppt_pkg::OFS_PAD_CFG;
   endsequence
   property p_setup;
      $rose(stb) && plain |-> int'(pre_r) == (4 * m[7:6] + 1) * QDIV;
   endproperty
   property p_wr_len;
      $fell(wr_strobe) && plain |-> int'(hi_r) == (4 * m[5:2] + 2) * QDIV;
   endproperty
   property p_rd_len;
      $fell(rd_strobe) && plain |-> int'(hi_r) == (4 * m[5:2] + 3) * QDIV;
   endproperty
   property p_wr_hold;
      xfer_done && wr_r && plain |-> int'(post_r) == (4 * m[1:0] + 1) * QDIV;
   endproperty
   property p_rd_hold;
      xfer_done && !wr_r && plain && m[1:0] != 2'h0
         |-> int'(post_r) == 4 * m[1:0] * QDIV;
   endproperty
   property p_wr_drive;
      $fell(wr_strobe) |-> !data_oe_n [*1] ##1 !data_oe_n;
   endproperty
   property p_ack_wait;
      xfer_done && m[15:14] == 2'h2 |-> seen_r;
   endproperty
   property p_ttl;
      s_pad_wr |=> ttl_input_select == $past(reg_wdata[0]);
   endproperty
   a_setup: assert property (p_setup) else $error("setup length");
   a_wr_len: assert property (p_wr_len) else $error("write width");
   a_rd_len: assert property (p_rd_len) else $error("read width");
   a_wr_hold: assert property (p_wr_hold) else $error("write hold");
   a_rd_hold: assert property (p_rd_hold) else $error("read hold");
   a_wr_drive: assert property (p_wr_drive) else $error("data drop");
   a_ack_wait: assert property (p_ack_wait) else $error("no ack");
   a_ttl: assert property (p_ttl) else $error("buffer select");
endmodule

// file: ppt_partner.sv
// Model of the parallel memory or peripheral on the master side.
// Assumes strobes active high; acknowledge delay set by the bench.
`timescale 1ns/100ps
module ppt_partner (
   input wire logic clk_sys,
   input wire logic cs_out,
   input wire logic wr_strobe,
   input wire logic data_oe_n,
   input wire logic [15:0] data_out,
   input wire logic ack_en,
   input wire logic ack_pol,
   input wire logic [7:0] ack_dly,
   output logic [15:0] data_in,
   output logic transfer_ack_in,
   output logic [15:0] mem_r
);
   logic [7:0] cnt_r;
   logic ack_r;
   // One stored word, written by the write strobe
   always_ff @(posedge clk_sys) begin
      if (wr_strobe)
         mem_r <= data_out;
   end
   // Acknowledge after a set delay, held until deselect
   always_ff @(posedge clk_sys) begin
      cnt_r <= cs_out ? cnt_r + 8'h01 : 8'h00;
      ack_r <= ack_en && cs_out && cnt_r >= ack_dly;
   end
   assign transfer_ack_in = ack_r ? ack_pol : !ack_pol;
   // Bus shows inverse data when not read
   assign data_in = (cs_out && data_oe_n) ? mem_r : ~mem_r;
endmodule

// file: ppt_top_tb.sv
// Self-checking bench for the parallel port timing block.
// Assumes the partner model and the checker bound below.
`timescale 1ns/100ps
module ppt_top_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic xfer_req = 1'b0;
   logic xfer_write = 1'b0;
   logic xfer_cs = 1'b0;
   logic [15:0] xfer_wdata = 16'h0000;
   logic host_wr = 1'b0;
   logic host_rd = 1'b0;
   logic [1:0] host_addr = 2'h0;
   logic [7:0] host_wdata = 8'h00;
   logic ack_en = 1'b0;
   logic ack_pol = 1'b0;
   logic [7:0] ack_dly = 8'h03;
   logic [15:0] reg_rdata, xfer_rdata, data_out, data_in, mem_r;
   logic [7:0] host_rdata;
   logic xfer_done, cs_out, rd_strobe, wr_strobe, data_oe_n;
   logic transfer_ack_in, ttl_input_select;
   int n_fail = 0;
   int tests_run = 0;
   int cyc;
   int alt;
   always #2.5 clk_sys = ~clk_sys;
   ppt_top #(.QDIV(1)) uut (.clk_sys, .rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .xfer_req, .xfer_write, .xfer_cs, .xfer_wdata,
      .xfer_done, .xfer_rdata, .cs_out, .rd_strobe, .wr_strobe, .data_out,
      .data_oe_n, .data_in, .transfer_ack_in, .host_wr, .host_rd,
      .host_addr, .host_wdata, .host_rdata, .ttl_input_select);
   ppt_partner far (.clk_sys, .cs_out, .wr_strobe, .data_oe_n, .data_out,
      .ack_en, .ack_pol, .ack_dly, .data_in, .transfer_ack_in, .mem_r);
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic reg_wt(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask
   task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic host_op(input logic w, input logic [1:0] a);
      @(posedge clk_sys);
      host_addr <= a;
      host_wdata <= {6'h28, a};
      host_wr <= w;
      host_rd <= !w;
      @(posedge clk_sys);
      host_wr <= 1'b0;
      host_rd <= 1'b0;
      #1;
   endtask
   task automatic xfer(input logic cs, input logic w, input logic [15:0] d);
      @(posedge clk_sys);
      xfer_req <= 1'b1;
      xfer_cs <= cs;
      xfer_write <= w;
      xfer_wdata <= d;
      @(posedge clk_sys);
      xfer_req <= 1'b0;
      cyc = 0;
      do begin
         @(posedge clk_sys);
         #1;
         cyc++;
         if (cyc > 2000) begin
            n_fail++;
            $display("FAIL t=%0t transfer never ended", $time);
            conclude();
         end
      end while (xfer_done !== 1'b1);
      // Count alternate-master wait by polling the busy bit
      @(posedge clk_sys);
      reg_addr <= ppt_pkg::OFS_MSTAT;
      reg_rd <= 1'b1;
      alt = 0;
      do begin
         @(posedge clk_sys);
         #1;
         alt++;
      end while (reg_rdata[0] !== 1'b0 && alt < 60);
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      repeat (60) @(posedge clk_sys);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_reset();
      reg_chk(ppt_pkg::OFS_STATUS, 16'h008F);
      reg_chk(ppt_pkg::OFS_PAD_CFG, 16'h0000);
      reg_chk(4'h7, 16'h0000);
      reg_wt(ppt_pkg::OFS_CS1_MODE, 16'hFFFF);
      reg_chk(ppt_pkg::OFS_CS1_MODE, 16'hF8FF);
   endtask
   task automatic s_timing();
      logic [15:0] md;
      for (int b = 0; b < 4; b++) begin
         md = {b == 3 ? 2'h3 : 2'h0, 3'(b * 2 + 1), 3'h0, 2'(b), 4'(b * 5),
               2'(b)};
         reg_wt(ppt_pkg::OFS_CS1_MODE, md);
         reg_wt(ppt_pkg::OFS_CS2_MODE, md);
         xfer(b[0], 1'b1, 16'h1234 + 16'(b));
         check(mem_r, 16'h1234 + 16'(b));
         check(16'(alt), 16'(4 * (b * 2 + 4) + 1));
         xfer(b[0], 1'b0, 16'h0000);
         check(xfer_rdata, 16'h1234 + 16'(b));
      end
   endtask
   task automatic s_ack();
      reg_wt(ppt_pkg::OFS_CS1_MODE, 16'h400C);
      xfer(1'b0, 1'b0, 16'h0000);
      check(16'(cyc < 40), 16'h0001);
      reg_chk(ppt_pkg::OFS_MSTAT, 16'h1000);
      reg_wt(ppt_pkg::OFS_CS1_MODE, 16'h4000);
      xfer(1'b0, 1'b1, 16'h3C3C);
      check(16'(cyc >= 1020), 16'h0001);
      reg_wt(ppt_pkg::OFS_CS2_MODE, 16'h8004);
      reg_wt(ppt_pkg::OFS_CS2_CFG, 16'h0080);
      ack_pol <= 1'b1;
      ack_en <= 1'b1;
      ack_dly <= 8'h28;
      xfer(1'b1, 1'b1, 16'h0F0F);
      check(16'(cyc > 40), 16'h0001);
      reg_chk(ppt_pkg::OFS_MSTAT, 16'h0000);
      reg_wt(ppt_pkg::OFS_CS1_MODE, 16'h8004);
      ack_pol <= 1'b0;
      xfer(1'b0, 1'b0, 16'h0000);
      check(xfer_rdata, 16'h0F0F);
      check(16'(cyc > 40), 16'h0001);
      ack_en <= 1'b0;
   endtask
   task automatic s_slave();
      host_op(1'b1, 2'h0);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h038F);
      host_op(1'b1, 2'h3);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h8F8F);
      host_op(1'b1, 2'h1);
      reg_chk(ppt_pkg::OFS_STATUS, 16'hCF8F);
      reg_chk(ppt_pkg::OFS_IBUF0, 16'h00A0);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h4C8F);
      reg_wt(ppt_pkg::OFS_STATUS, 16'h0000);
      host_op(1'b0, 2'h2);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h0CCF);
      reg_wt(4'hD, 16'h005A);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h0C4C);
      host_op(1'b0, 2'h1);
      check({8'h00, host_rdata}, 16'h005A);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h0CCF);
      reg_wt(ppt_pkg::OFS_STATUS, 16'h0000);
      reg_chk(4'hB, 16'h00A3);
      reg_chk(ppt_pkg::OFS_STATUS, 16'h008F);
   endtask
   task automatic s_pad();
      reg_wt(ppt_pkg::OFS_PAD_CFG, 16'hFFFF);
      reg_chk(ppt_pkg::OFS_PAD_CFG, 16'h0001);
      check({15'h0000, ttl_input_select}, 16'h0001);
      reg_wt(ppt_pkg::OFS_PAD_CFG, 16'h0000);
      reg_chk(ppt_pkg::OFS_PAD_CFG, 16'h0000);
   endtask
   // Main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      s_reset();
      s_timing();
      s_ack();
      s_slave();
      s_pad();
      conclude();
   end
endmodule
bind ppt_top ppt_asserts #(.QDIV(QDIV)) chk (.clk_sys, .rst, .reg_addr,
   .reg_wdata, .reg_wr, .xfer_req, .xfer_write, .xfer_cs, .xfer_done,
   .cs_out, .rd_strobe, .wr_strobe, .data_oe_n, .transfer_ack_in,
   .ttl_input_select);
